// File: verilog/wec_pkg.sv
/*
 * Constants, field layout and status encoding of the engine program control and
 * status register bank.
 * Assumes a single 40 MHz system clock and an AXI4-Lite master with 32-bit data.
 */
package wec_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [31:0] WEC_ADDR_CTRL_STAT = 32'hE0014118;
  localparam logic [31:0] WEC_ADDR_RUN_CFG = 32'hE0014200;
  localparam logic [31:0] WEC_ADDR_IRQ_STAT = 32'hE0014204;
  localparam logic [31:0] WEC_ADDR_IRQ_MASK = 32'hE0014208;
  localparam logic [31:0] WEC_RESET_VALUE = 32'h00000000;

  // ==========================================================================
  // Control and status fields.
  localparam int WEC_CUR_STATE_LSB = 24;
  localparam int WEC_ALPHA_INIT_LSB = 16;
  localparam int WEC_SW_INPUT_BIT = 11;
  localparam int WEC_STATUS_LSB = 8;
  localparam int WEC_STATUS_W = 3;
  localparam int WEC_PAUSE_BIT = 1;
  localparam int WEC_VALID_BIT = 0;
  localparam int WEC_SW_INPUT_INDEX = 30;
  localparam int WEC_STATE_W = 8;
  localparam int WEC_EARLY_W = 8;

  // Run configuration fields.
  localparam int WEC_SWREQ_BIT = 0;
  localparam int WEC_DONE_EN_BIT = 1;
  localparam int WEC_DONE_STATE_LSB = 24;

  // Interrupt bits.
  localparam int WEC_IRQ_DONE = 0;
  localparam int WEC_IRQ_SWITCHED = 1;
  localparam int WEC_IRQ_ERROR = 2;
  localparam int WEC_IRQ_W = 3;

  localparam logic [1:0] WEC_RESP_OKAY = 2'h0;
  localparam logic [1:0] WEC_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    WEC_ST_NOT_VALID,
    WEC_ST_UNUSED,
    WEC_ST_ARMED,
    WEC_ST_RUNNING,
    WEC_ST_DONE,
    WEC_ST_PAUSED,
    WEC_ST_SWITCHING,
    WEC_ST_ERROR
  } wec_stat_e;

endpackage : wec_pkg

// File: verilog/wec_run_ctrl.sv
/*
 * Run controller of the waveform engine: status code state machine with pause
 * context.
 * Assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module wec_run_ctrl
  import wec_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic valid, // Program valid bit.
  input wire logic pause, // Pause bit.
  input wire logic switch_req, // Pending switch request.
  input wire logic done_hit, // Completion state reached with checking on.
  input wire logic switch_done, // Engine finished a program switch.
  input wire logic engine_error, // Engine reports an error.
  output wec_pkg::wec_stat_e status, // Present status code.
  output logic start_pulse, // First start this cycle.
  output logic switch_clear, // Switch request completes this cycle.
  output logic done_event, // Completion reached this cycle.
  output logic error_event // Error entered this cycle.
);
  import wec_pkg::*;

  wec_stat_e st_q, st_d, ctx_q, ctx_d;

  assign status = st_q;

  always_comb begin
    st_d = st_q;
    ctx_d = ctx_q;
    start_pulse = 1'b0;
    switch_clear = 1'b0;
    done_event = 1'b0;
    error_event = 1'b0;
    if (!valid) begin
      st_d = WEC_ST_NOT_VALID;
    end else begin
      case (st_q)
        WEC_ST_NOT_VALID: st_d = WEC_ST_ARMED;
        WEC_ST_ARMED: begin
          if (switch_req) begin
            st_d = WEC_ST_RUNNING;
            start_pulse = 1'b1;
            switch_clear = 1'b1;
          end
        end
        WEC_ST_RUNNING, WEC_ST_DONE, WEC_ST_SWITCHING: begin
          if (engine_error) begin
            st_d = WEC_ST_ERROR;
            error_event = 1'b1;
          end else if (pause) begin
            st_d = WEC_ST_PAUSED;
            ctx_d = st_q;
          end else if (st_q == WEC_ST_SWITCHING) begin
            if (switch_done) begin
              st_d = WEC_ST_RUNNING;
              switch_clear = 1'b1;
            end
          end else if (switch_req) begin
            st_d = WEC_ST_SWITCHING;
          end else if (st_q == WEC_ST_RUNNING && done_hit) begin
            st_d = WEC_ST_DONE;
            done_event = 1'b1;
          end
        end
        WEC_ST_PAUSED: begin
          if (engine_error) begin
            st_d = WEC_ST_ERROR;
            error_event = 1'b1;
          end else if (!pause) begin
            st_d = ctx_q;
          end
        end
        WEC_ST_ERROR: st_d = WEC_ST_ERROR;
        default: st_d = WEC_ST_NOT_VALID;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= WEC_ST_NOT_VALID;
      ctx_q <= WEC_ST_RUNNING;
    end else begin
      st_q <= st_d;
      ctx_q <= ctx_d;
    end
  end

endmodule : wec_run_ctrl

// File: verilog/wec_top.sv
/*
 * Engine program control and status register bank with AXI4-Lite slave,
 * early-output register, completion signal and interrupt.
 * Assumes the state machine datapath runs on mclk and holds its state while
 * run_enable is low.
 */
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module wec_top
  import wec_pkg::*;
(
  input wire logic mclk, // System clock, 40 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [wec_pkg::WEC_STATE_W-1:0] present_state, // Engine present state.
  input wire logic [wec_pkg::WEC_EARLY_W-1:0] early_next, // Early outputs from engine.
  input wire logic early_we, // Engine updates early outputs.
  input wire logic switch_done, // Engine finished a switch.
  input wire logic engine_error, // Engine error.
  output logic run_enable, // Engine may advance.
  output logic outputs_default, // Engine outputs held at defaults.
  output logic [wec_pkg::WEC_EARLY_W-1:0] early_out, // Early outputs.
  output logic sw_lambda, // Software input to engine input 30.
  output logic completion_signal, // Completion state reached.
  output logic irq // Interrupt, level.
);
  import wec_pkg::*;

  // ==========================================================================
  // Bus slave.
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_go, rd_go;
  logic [31:0] wr_val;

  // Control registers.
  logic [WEC_EARLY_W-1:0] alpha_init_q, alpha_init_d;
  logic lambda_q, lambda_d, pause_q, pause_d, valid_q, valid_d;
  logic swreq_q, swreq_d, done_en_q, done_en_d;
  logic [WEC_STATE_W-1:0] done_state_q, done_state_d;
  logic [WEC_IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, irq_set;

  // Outputs.
  logic run_q, run_d, dflt_q, dflt_d, compl_q, compl_d, irq_q, irq_d;
  logic [WEC_EARLY_W-1:0] early_q, early_d;

  wec_stat_e status;
  logic start_pulse, switch_clear, done_event, error_event, done_hit, started;

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign run_enable = run_q;
  assign outputs_default = dflt_q;
  assign early_out = early_q;
  assign sw_lambda = lambda_q;
  assign completion_signal = compl_q;
  assign irq = irq_q;

  // Merges the written bytes into the old register value.
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  assign wr_go = aw_full_q && w_full_q && !bvalid_q;
  assign rd_go = s_axi_arvalid && arready_q;

  always_comb begin
    aw_full_d = aw_full_q;
    awaddr_d = awaddr_q;
    w_full_d = w_full_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_full_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (awaddr_q == WEC_ADDR_CTRL_STAT || awaddr_q == WEC_ADDR_RUN_CFG ||
                 awaddr_q == WEC_ADDR_IRQ_STAT || awaddr_q == WEC_ADDR_IRQ_MASK) ?
                WEC_RESP_OKAY : WEC_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d = WEC_RESP_OKAY;
      rdata_d = WEC_RESET_VALUE;
      case (s_axi_araddr)
        WEC_ADDR_CTRL_STAT: begin
          rdata_d[WEC_CUR_STATE_LSB +: WEC_STATE_W] = present_state;
          rdata_d[WEC_ALPHA_INIT_LSB +: WEC_EARLY_W] = alpha_init_q;
          rdata_d[WEC_SW_INPUT_BIT] = lambda_q;
          rdata_d[WEC_STATUS_LSB +: WEC_STATUS_W] = status;
          rdata_d[WEC_PAUSE_BIT] = pause_q;
          rdata_d[WEC_VALID_BIT] = valid_q;
        end
        WEC_ADDR_RUN_CFG: begin
          rdata_d[WEC_DONE_STATE_LSB +: WEC_STATE_W] = done_state_q;
          rdata_d[WEC_DONE_EN_BIT] = done_en_q;
          rdata_d[WEC_SWREQ_BIT] = swreq_q;
        end
        WEC_ADDR_IRQ_STAT: rdata_d[WEC_IRQ_W-1:0] = irq_stat_q;
        WEC_ADDR_IRQ_MASK: rdata_d[WEC_IRQ_W-1:0] = irq_mask_q;
        default: rresp_d = WEC_RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    awready_d = !aw_full_d && !bvalid_d;
    wready_d = !w_full_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_q <= 1'b0;
      awaddr_q <= WEC_RESET_VALUE;
      w_full_q <= 1'b0;
      wdata_q <= WEC_RESET_VALUE;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= WEC_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= WEC_RESP_OKAY;
      rdata_q <= WEC_RESET_VALUE;
    end else begin
      aw_full_q <= aw_full_d;
      awaddr_q <= awaddr_d;
      w_full_q <= w_full_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // Control registers.
  always_comb begin
    alpha_init_d = alpha_init_q;
    lambda_d = lambda_q;
    pause_d = pause_q;
    valid_d = valid_q;
    done_en_d = done_en_q;
    done_state_d = done_state_q;
    irq_mask_d = irq_mask_q;
    swreq_d = swreq_q;
    irq_stat_d = irq_stat_q;
    wr_val = WEC_RESET_VALUE;
    if (switch_clear) begin
      swreq_d = 1'b0;
    end
    if (wr_go && awaddr_q == WEC_ADDR_CTRL_STAT) begin
      wr_val = merge({alpha_init_q, alpha_init_q, alpha_init_q, alpha_init_q},
                     wdata_q, wstrb_q);
      alpha_init_d = wr_val[WEC_ALPHA_INIT_LSB +: WEC_EARLY_W];
      wr_val = merge({20'h00000, lambda_q, 9'h000, pause_q, valid_q}, wdata_q, wstrb_q);
      lambda_d = wr_val[WEC_SW_INPUT_BIT];
      pause_d = wr_val[WEC_PAUSE_BIT];
      valid_d = wr_val[WEC_VALID_BIT];
    end
    if (wr_go && awaddr_q == WEC_ADDR_RUN_CFG) begin
      wr_val = merge({done_state_q, 22'h000000, done_en_q, swreq_q}, wdata_q, wstrb_q);
      done_state_d = wr_val[WEC_DONE_STATE_LSB +: WEC_STATE_W];
      done_en_d = wr_val[WEC_DONE_EN_BIT];
      // A fresh request written now outranks the hardware clear.
      swreq_d = wr_val[WEC_SWREQ_BIT] | swreq_d & ~switch_clear;
    end
    if (wr_go && awaddr_q == WEC_ADDR_IRQ_MASK && wstrb_q[0]) begin
      irq_mask_d = wdata_q[WEC_IRQ_W-1:0];
    end
    if (wr_go && awaddr_q == WEC_ADDR_IRQ_STAT && wstrb_q[0]) begin
      irq_stat_d = irq_stat_q & ~wdata_q[WEC_IRQ_W-1:0];
    end
    // New events win over a clear in the same cycle.
    irq_stat_d = irq_stat_d | irq_set;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alpha_init_q <= '0;
      lambda_q <= 1'b0;
      pause_q <= 1'b0;
      valid_q <= 1'b0;
      swreq_q <= 1'b0;
      done_en_q <= 1'b0;
      done_state_q <= '0;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      alpha_init_q <= alpha_init_d;
      lambda_q <= lambda_d;
      pause_q <= pause_d;
      valid_q <= valid_d;
      swreq_q <= swreq_d;
      done_en_q <= done_en_d;
      done_state_q <= done_state_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // ==========================================================================
  // Run control and engine-facing outputs.
  assign started = status == WEC_ST_RUNNING || status == WEC_ST_DONE ||
                   status == WEC_ST_SWITCHING || status == WEC_ST_PAUSED;
  assign done_hit = done_en_q && present_state == done_state_q;

  wec_run_ctrl u_run (
    .mclk(mclk),
    .reset_n(reset_n),
    .valid(valid_q),
    .pause(pause_q),
    .switch_req(swreq_q),
    .done_hit(done_hit),
    .switch_done(switch_done),
    .engine_error(engine_error),
    .status(status),
    .start_pulse(start_pulse),
    .switch_clear(switch_clear),
    .done_event(done_event),
    .error_event(error_event)
  );

  always_comb begin
    irq_set = '0;
    irq_set[WEC_IRQ_DONE] = done_event;
    irq_set[WEC_IRQ_SWITCHED] = switch_clear && status == WEC_ST_SWITCHING;
    irq_set[WEC_IRQ_ERROR] = error_event;
    run_d = status == WEC_ST_RUNNING || status == WEC_ST_DONE || status == WEC_ST_SWITCHING;
    dflt_d = !valid_q;
    compl_d = done_hit && started;
    irq_d = |(irq_stat_q & irq_mask_q);
    early_d = early_q;
    if (!valid_q) begin
      early_d = '0;
    end else if (start_pulse) begin
      early_d = alpha_init_q;
    end else if (early_we && run_q) begin
      early_d = early_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 1'b0;
      dflt_q <= 1'b1;
      compl_q <= 1'b0;
      irq_q <= 1'b0;
      early_q <= '0;
    end else begin
      run_q <= run_d;
      dflt_q <= dflt_d;
      compl_q <= compl_d;
      irq_q <= irq_d;
      early_q <= early_d;
    end
  end

  // ==========================================================================
  // Checks.
  wec_stat_e last_active_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      last_active_q <= WEC_ST_NOT_VALID;
    end else if (status != WEC_ST_PAUSED) begin
      last_active_q <= status;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_ctrl_read;
    rd_go && s_axi_araddr == WEC_ADDR_CTRL_STAT;
  endsequence

  sequence s_release;
    status == WEC_ST_PAUSED && !pause_q && valid_q && !engine_error;
  endsequence

  a_state_field: assert property (s_ctrl_read |=>
    s_axi_rdata[WEC_CUR_STATE_LSB +: WEC_STATE_W] == $past(present_state) &&
    s_axi_rdata[WEC_STATUS_LSB +: WEC_STATUS_W] == $past(status))
    else $error("present state or status not shown on read");
  a_alpha_load: assert property (start_pulse |=> early_out == $past(alpha_init_q))
    else $error("early outputs not loaded at start");
  a_lambda_out: assert property (wr_go && awaddr_q == WEC_ADDR_CTRL_STAT && wstrb_q[1]
    |=> ##1 sw_lambda == $past(wdata_q[WEC_SW_INPUT_BIT], 2))
    else $error("software input not passed on");
  a_invalid_code: assert property (!valid_q |=> status == WEC_ST_NOT_VALID && outputs_default)
    else $error("invalid program not reported");
  a_start_run: assert property (status == WEC_ST_ARMED && swreq_q && valid_q
    |=> status == WEC_ST_RUNNING ##1 run_enable)
    else $error("start request did not run the engine");
  a_pause_hold: assert property (status == WEC_ST_RUNNING && pause_q && valid_q
    && !engine_error |=> status == WEC_ST_PAUSED ##1 !run_enable)
    else $error("pause did not suspend the engine");
  a_resume_ctx: assert property (s_release |=> status == $past(last_active_q))
    else $error("resume did not return to the suspended context");
  a_switch_clear: assert property (status == WEC_ST_SWITCHING && switch_done && valid_q
    && !pause_q && !engine_error && !wr_go |=> !swreq_q && status == WEC_ST_RUNNING)
    else $error("switch request not cleared on completion");
  a_completion: assert property (done_en_q && present_state == done_state_q && started
    |=> completion_signal)
    else $error("completion signal missing");
  a_error_code: assert property (status == WEC_ST_RUNNING && valid_q && engine_error
    |=> status == WEC_ST_ERROR && irq_stat_q[WEC_IRQ_ERROR])
    else $error("error not reported");

endmodule : wec_top

// File: tb/test_waveform_engine_ctrl_status.sv
/* Self-checking bench of the engine program control and status register bank.
   Assumes wec_pkg and wec_top are compiled first and a 40 MHz mclk. */
`timescale 1ns/1ps
module test_waveform_engine_ctrl_status;
  import wec_pkg::*;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [7:0] ps;
    logic [31:0] rd;
    logic [1:0] runcmp;
    logic [7:0] early;
  } wec_tb_row_s;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] present_state = 8'h10, early_next = 8'h00;
  logic early_we = 1'b0, switch_done = 1'b0, engine_error = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic run_enable, outputs_default, sw_lambda, completion_signal, irq;
  logic [7:0] early_out;
  int num_errors = 0;
  int checks = 0;
  wec_tb_row_s rows [6];

  always #12.5 mclk = ~mclk;

  wec_top dut (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .present_state(present_state), .early_next(early_next),
    .early_we(early_we), .switch_done(switch_done), .engine_error(engine_error),
    .run_enable(run_enable), .outputs_default(outputs_default), .early_out(early_out),
    .sw_lambda(sw_lambda), .completion_signal(completion_signal), .irq(irq));

  // ==========================================================================
  // Shared tasks.
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task test_done;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task axi_write(input logic [31:0] a, input logic [31:0] d);
    int n;
    bit got;
    n = 0;
    got = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got && n < 50) begin
      @(posedge mclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        resp = s_axi_bresp;
        got = 1;
        s_axi_bready <= 1'b0;
      end
    end
    check("write answer", 32'(got), 32'h1);
  endtask : axi_write

  task axi_read(input logic [31:0] a);
    int n;
    bit got;
    n = 0;
    got = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got && n < 50) begin
      @(posedge mclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        got = 1;
        s_axi_rready <= 1'b0;
      end
    end
    check("read answer", 32'(got), 32'h1);
  endtask : axi_read

  task pulse(input int which);
    @(posedge mclk);
    if (which == 0) switch_done <= 1'b1;
    if (which == 1) early_we <= 1'b1;
    if (which == 2) engine_error <= 1'b1;
    @(posedge mclk);
    {switch_done, early_we, engine_error} <= 3'b000;
    repeat (4) @(posedge mclk);
  endtask : pulse

  // ==========================================================================
  // Watchdog.
  initial begin
    #500000;
    num_errors++;
    $display("BAD watchdog expected finish seen hang");
    test_done();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    rows[0] = '{WEC_ADDR_CTRL_STAT, 32'h00A50801, 8'h10, 32'h10A50A01, 2'b00, 8'h00};
    rows[1] = '{WEC_ADDR_RUN_CFG, 32'h33000003, 8'h10, 32'h10A50B01, 2'b10, 8'hA5};
    rows[2] = '{WEC_ADDR_CTRL_STAT, 32'h00A50803, 8'h10, 32'h10A50D03, 2'b00, 8'hA5};
    rows[3] = '{WEC_ADDR_CTRL_STAT, 32'h00A50801, 8'h10, 32'h10A50B01, 2'b10, 8'hA5};
    rows[4] = '{WEC_ADDR_CTRL_STAT, 32'h00A50801, 8'h33, 32'h33A50C01, 2'b11, 8'hA5};
    rows[5] = '{WEC_ADDR_RUN_CFG, 32'h33000003, 8'h33, 32'h33A50E01, 2'b11, 8'hA5};
    @(posedge mclk);
    #1;
    check("default in reset", {irq, outputs_default}, 32'h1);
    @(posedge mclk);
    reset_n <= 1'b1;
    axi_read(WEC_ADDR_CTRL_STAT);
    check("ctrl after reset", rd, 32'h10000000);
    foreach (rows[i]) begin
      @(posedge mclk);
      present_state <= rows[i].ps;
      axi_write(rows[i].addr, rows[i].wdata);
      repeat (4) @(posedge mclk);
      check("run and completion", {run_enable, completion_signal}, rows[i].runcmp);
      check("early_out", early_out, rows[i].early);
      axi_read(WEC_ADDR_CTRL_STAT);
      check("ctrl_stat", rd, rows[i].rd);
      $display("test row %0d done", i);
    end
    present_state <= 8'h10;
    pulse(0);
    axi_read(WEC_ADDR_RUN_CFG);
    check("switch request", rd, 32'h33000002);
    axi_read(WEC_ADDR_IRQ_STAT);
    check("irq status", rd, 32'h3);
    check("irq masked", irq, 32'h0);
    axi_write(WEC_ADDR_IRQ_MASK, 32'h1);
    repeat (3) @(posedge mclk);
    check("irq raised", irq, 32'h1);
    axi_write(WEC_ADDR_IRQ_STAT, 32'h1);
    repeat (3) @(posedge mclk);
    check("irq cleared", irq, 32'h0);
    $display("test interrupt done");
    early_next <= 8'h3C;
    pulse(1);
    check("early update", {sw_lambda, early_out}, 32'h13C);
    pulse(2);
    axi_read(WEC_ADDR_CTRL_STAT);
    check("error code", rd, 32'h10A50F01);
    check("error halts", run_enable, 32'h0);
    axi_write(WEC_ADDR_CTRL_STAT, 32'h00A50800);
    repeat (4) @(posedge mclk);
    axi_read(WEC_ADDR_CTRL_STAT);
    check("invalid code", rd, 32'h10A50800);
    check("outputs default", {outputs_default, early_out}, 32'h100);
    $display("test error and invalid done");
    axi_read(32'hE0014300);
    check("unmapped read", {resp, rd[29:0]}, 32'h80000000);
    axi_write(32'hE0014300, 32'hFFFFFFFF);
    check("unmapped write", resp, WEC_RESP_SLVERR);
    @(posedge mclk);
    s_axi_wstrb <= 4'h4;
    axi_write(WEC_ADDR_CTRL_STAT, 32'hFF5A0000);
    s_axi_wstrb <= 4'hF;
    axi_read(WEC_ADDR_CTRL_STAT);
    check("byte strobe write", rd, 32'h105A0800);
    @(posedge mclk);
    reset_n <= 1'b0;
    @(posedge mclk);
    reset_n <= 1'b1;
    axi_read(WEC_ADDR_CTRL_STAT);
    check("ctrl after second reset", rd, 32'h10000000);
    $display("test bus and reset done");
    test_done();
  end
endmodule : test_waveform_engine_ctrl_status
